// ### imtc_pkg.sv
package imtc_pkg;

  // Core timebase
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
  localparam int unsigned CYC_PER_US      = CLK_HZ / 1_000_000;
  localparam int          CNT_W           = 25;
  localparam int          STAB_W          = 11;
  localparam int          PULSE_W         = 3;

  // Mode transition times in their own units
  localparam int unsigned T_TURN_ON_MS    = 1750;
  localparam int unsigned T_GYRO_WAKE_MS  = 60;
  localparam int unsigned T_ACCEL_WAKE_MS = 3;
  localparam int unsigned T_MAG_WAKE_MS   = 12;
  localparam int unsigned T_WARM_WAKE_MS  = 5;
  localparam int unsigned T_OFF_SPI_US    = 40;
  localparam int unsigned T_OFF_I2C_US    = 100;
  localparam int unsigned STAB_RATE_HZ    = 8100;
  localparam int unsigned SETTLE_PERIODS  = 3;

  // Derived cycle counts
  localparam int unsigned TURN_ON_CYC     = T_TURN_ON_MS * CYC_PER_MS;
  localparam int unsigned GYRO_WAKE_CYC   = T_GYRO_WAKE_MS * CYC_PER_MS;
  localparam int unsigned ACCEL_WAKE_CYC  = T_ACCEL_WAKE_MS * CYC_PER_MS;
  localparam int unsigned MAG_WAKE_CYC    = T_MAG_WAKE_MS * CYC_PER_MS;
  localparam int unsigned WARM_WAKE_CYC   = T_WARM_WAKE_MS * CYC_PER_MS;
  localparam int unsigned OFF_SPI_CYC     = T_OFF_SPI_US * CYC_PER_US;
  // Strictly under the I2C bound, so one cycle short of it
  localparam int unsigned OFF_I2C_CYC     = T_OFF_I2C_US * CYC_PER_US - 1;
  localparam int unsigned STAB_PERIOD_CYC = CLK_HZ / STAB_RATE_HZ;
  localparam int unsigned PIN_PULSE_CYC   = 4;

  // Rate field codes
  localparam logic [2:0] GYRO_RATE_STAB    = 3'h6;
  localparam logic [2:0] GYRO_RATE_STAB_LL = 3'h7;
  localparam logic [2:0] GYRO_RATE_WARM    = 3'h4;
  localparam logic [2:0] ACCEL_RATE_BASE   = 3'h0;

  // Output data formats
  localparam logic [1:0] FMT_RAW      = 2'h0;
  localparam logic [1:0] FMT_INCR     = 2'h1;
  localparam logic [1:0] FMT_INCR_MAG = 2'h2;

  // Output-rate period per rate code, halving from 1 kHz
  localparam int unsigned ODR_PERIOD_DEF [8] = '{10_000, 20_000, 40_000, 80_000,
                                                160_000, 320_000, 640_000, 1_280_000};

  typedef enum logic [2:0] {
    ST_BOOT    = 3'h0,
    ST_DEFAULT = 3'h1,
    ST_DOWN    = 3'h2,
    ST_WAKE    = 3'h3,
    ST_SETTLE  = 3'h4,
    ST_ACTIVE  = 3'h5,
    ST_OFF     = 3'h6,
    ST_SWITCH  = 3'h7
  } imtc_state_t;

endpackage

// ### imtc_mode_ctrl.sv
`timescale 1ns/1ps
// Behaviour
// - Gyro rate 110 selects plain stabilization, 8.1 kHz SPI gyro stream, no accel
// - Plain stabilization marks each gyro sample with a first interrupt pin fall
// - Gyro rate 111 selects low-latency mode, sample marked by second pin rise
// - Low-latency mode lets accel run at 1 kHz when accel rate is 000
// - Stabilization SPI uses three or four wires per the wire count select
// - Accel, gyro and fusion enabled give velocity and orientation increments
// - Magnetometer enable in fusion mode adds magnetic field values
// - Polled sample select with fusion lets host poll data asynchronously
// - Power-up or reset release enters the power-on default state
// - Reaching default after reset, no power or power-down takes 1.75 s
// - Wake-up intervals run from second interrupt pin rising to valid data
// - Gyro turn-on takes 60 ms wake plus filter settling
// - Accel turn-on takes 3 ms wake plus filter settling
// - Default to mag or mag plus accel takes 12 ms plus settling
// - Gyro wake from warm start takes 5 ms plus settling
// - Filter settling lasts three output-rate periods after wake-up
// - Powered to sensors-off takes between one and two output-rate periods
// - Sensors-off to sensors-off takes under 100 us on I2C, 40 us on SPI
// - Default state keeps all sensors off with the clock running
// - Shutdown bit powers blocks down, keeps interfaces, preserves outputs
module imtc_mode_ctrl
  import imtc_pkg::*;
#(
  parameter int unsigned TURN_ON_CYCLES     = TURN_ON_CYC,
  parameter int unsigned GYRO_WAKE_CYCLES   = GYRO_WAKE_CYC,
  parameter int unsigned ACCEL_WAKE_CYCLES  = ACCEL_WAKE_CYC,
  parameter int unsigned MAG_WAKE_CYCLES    = MAG_WAKE_CYC,
  parameter int unsigned WARM_WAKE_CYCLES   = WARM_WAKE_CYC,
  parameter int unsigned ODR_PERIOD_CYC [8] = ODR_PERIOD_DEF,
  parameter int          DATA_W             = 48
) (
  input  wire logic              ref_clk_in,
  input  wire logic              rst_in,
  input  wire logic [2:0]        gyro_rate_select_in,
  input  wire logic [2:0]        accel_rate_select_in,
  input  wire logic              accel_enable_bit_in,
  input  wire logic              gyro_enable_bit_in,
  input  wire logic              magnetometer_enable_bit_in,
  input  wire logic              fusion_engine_enable_bit_in,
  input  wire logic              polled_sample_select_in,
  input  wire logic              serial_wire_count_select_in,
  input  wire logic              sensor_shutdown_bit_in,
  input  wire logic              host_iface_spi_in,
  input  wire logic              poll_request_in,
  input  wire logic [DATA_W-1:0] gyro_sample_in,
  input  wire logic              spi_sclk_in,
  input  wire logic              spi_cs_n_in,
  output logic                   spi_sdo_out,
  output logic                   spi_sdo_oe_out,
  output logic                   spi_sdio_out,
  output logic                   spi_sdio_oe_out,
  output logic                   first_interrupt_pin_out,
  output logic                   second_interrupt_pin_out,
  output logic                   gyro_power_out,
  output logic                   accel_power_out,
  output logic                   mag_power_out,
  output logic                   fusion_power_out,
  output logic                   clock_run_out,
  output logic                   data_valid_out,
  output logic                   data_ready_out,
  output logic [1:0]             output_format_out,
  output logic [DATA_W-1:0]      sample_out,
  output logic [2:0]             device_state_out
);

  imtc_state_t        st_r;
  logic [CNT_W-1:0]   cnt_r, odr_cnt_r, odr_period;
  logic [STAB_W-1:0]  stab_cnt_r;
  logic [PULSE_W-1:0] pulse_cnt_r;
  logic [4:0]         cfg_r, cfg_now;
  logic [1:0]         sclk_sync_r, csn_sync_r;
  logic [DATA_W-1:0]  shift_r;
  logic               off_armed_r, warm_r, sclk_d_r, csn_d_r, drive_r;
  logic               odr_tick, stab_tick, stab_fire, stab_plain, stab_ll, want_on;
  logic               powered, active, fusion_on, sample_evt, sclk_fall, cs_start;

  // Wake time by sensor mix; gyro dominates, then mag, then accel
  function automatic logic [CNT_W-1:0] wake_load(input logic g, input logic a, input logic m, input logic w);
    int unsigned n;
    n = 1;
    if (a) n = ACCEL_WAKE_CYCLES;
    if (m) n = MAG_WAKE_CYCLES;
    if (g) n = w ? WARM_WAKE_CYCLES : GYRO_WAKE_CYCLES;
    return CNT_W'(n - 1);
  endfunction

  // Mode decode from the live configuration bits
  assign stab_plain = (gyro_rate_select_in == GYRO_RATE_STAB);
  assign stab_ll    = (gyro_rate_select_in == GYRO_RATE_STAB_LL);
  // Accel is barred in plain mode and limited to the base rate in low latency
  assign cfg_now[1] = accel_enable_bit_in & ~stab_plain &
                      (~stab_ll | (accel_rate_select_in == ACCEL_RATE_BASE));
  assign cfg_now[0] = gyro_enable_bit_in | stab_plain | stab_ll;
  assign cfg_now[2] = magnetometer_enable_bit_in;
  assign cfg_now[3] = stab_plain;
  assign cfg_now[4] = stab_ll;
  assign want_on    = cfg_now[0] | cfg_now[1] | cfg_now[2];
  assign active     = (st_r == ST_ACTIVE);
  assign powered    = (st_r == ST_WAKE) || (st_r == ST_SETTLE) || active || (st_r == ST_OFF);
  assign fusion_on  = fusion_engine_enable_bit_in & gyro_enable_bit_in & accel_enable_bit_in;

  // Output-rate timebase follows gyro rate when the gyro enable bit is set, else accel rate
  assign odr_period = CNT_W'(ODR_PERIOD_CYC[gyro_enable_bit_in ? gyro_rate_select_in
                                                              : accel_rate_select_in]);
  assign odr_tick   = (odr_cnt_r == '0);
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      odr_cnt_r <= '0;
    end else if (odr_tick || odr_cnt_r >= odr_period) begin
      odr_cnt_r <= odr_period - 1'b1;
    end else begin
      odr_cnt_r <= odr_cnt_r - 1'b1;
    end
  end

  // Fixed stabilization sample timebase
  assign stab_tick = (stab_cnt_r == '0);
  // Waits for valid so the second pin has dropped after settling before its first rise
  assign stab_fire = stab_tick & active & data_valid_out & (cfg_r[3] | cfg_r[4]);
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      stab_cnt_r <= '0;
    end else if (stab_tick) begin
      stab_cnt_r <= STAB_W'(STAB_PERIOD_CYC - 1);
    end else begin
      stab_cnt_r <= stab_cnt_r - 1'b1;
    end
  end

  // Warm start is remembered only while the sensors sit off in default
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      warm_r <= 1'b0;
    end else if (st_r == ST_DEFAULT) begin
      warm_r <= (gyro_rate_select_in == GYRO_RATE_WARM) & ~gyro_enable_bit_in;
    end else if (st_r == ST_BOOT || st_r == ST_DOWN) begin
      warm_r <= 1'b0;
    end
  end

  // Mode sequencer; one down counter times the boot, switch, wake, settle and off waits
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_r        <= ST_BOOT;
      cnt_r       <= CNT_W'(TURN_ON_CYCLES - 1);
      cfg_r       <= '0;
      off_armed_r <= 1'b0;
    end else begin
      unique case (st_r)
        ST_BOOT: begin
          if (cnt_r == '0) st_r <= ST_DEFAULT;
          else cnt_r <= cnt_r - 1'b1;
        end
        ST_DEFAULT: begin
          if (sensor_shutdown_bit_in) begin
            st_r  <= ST_SWITCH;
            cnt_r <= CNT_W'((host_iface_spi_in ? OFF_SPI_CYC : OFF_I2C_CYC) - 1);
          end else if (want_on) begin
            st_r  <= ST_WAKE;
            cnt_r <= wake_load(cfg_now[0], cfg_now[1], cfg_now[2], warm_r);
            cfg_r <= cfg_now;
          end
        end
        ST_SWITCH: begin
          if (cnt_r == '0) st_r <= ST_DOWN;
          else cnt_r <= cnt_r - 1'b1;
        end
        ST_DOWN: begin
          // Leaving power-down costs a full turn-on again
          if (!sensor_shutdown_bit_in) begin
            st_r  <= ST_BOOT;
            cnt_r <= CNT_W'(TURN_ON_CYCLES - 1);
          end
        end
        ST_WAKE: begin
          if (cnt_r == '0) begin
            st_r  <= ST_SETTLE;
            cnt_r <= CNT_W'(SETTLE_PERIODS * odr_period - 1);
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        ST_SETTLE: begin
          if (cnt_r == '0) st_r <= ST_ACTIVE;
          else cnt_r <= cnt_r - 1'b1;
        end
        ST_ACTIVE: begin
          if (!want_on || sensor_shutdown_bit_in) begin
            st_r        <= ST_OFF;
            off_armed_r <= 1'b0;
          end else if (cfg_now != cfg_r) begin
            st_r  <= ST_WAKE;
            cnt_r <= wake_load(cfg_now[0], cfg_now[1], cfg_now[2], 1'b0);
            cfg_r <= cfg_now;
          end
        end
        ST_OFF: begin
          // Align to the next rate tick, then one full period: 1 to 2 periods
          if (!off_armed_r) begin
            if (odr_tick) begin
              off_armed_r <= 1'b1;
              cnt_r       <= odr_period - 1'b1;
            end
          end else if (cnt_r == '0) begin
            st_r <= ST_DEFAULT;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
      endcase
    end
  end

  // Power, format and status outputs
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      gyro_power_out    <= 1'b0;
      accel_power_out   <= 1'b0;
      mag_power_out     <= 1'b0;
      fusion_power_out  <= 1'b0;
      clock_run_out     <= 1'b0;
      data_valid_out    <= 1'b0;
      output_format_out <= FMT_RAW;
      device_state_out  <= ST_BOOT;
    end else begin
      gyro_power_out    <= powered & cfg_r[0];
      accel_power_out   <= powered & cfg_r[1];
      mag_power_out     <= powered & cfg_r[2];
      fusion_power_out  <= powered & fusion_on;
      clock_run_out     <= (st_r != ST_BOOT) && (st_r != ST_DOWN);
      data_valid_out    <= active;
      output_format_out <= fusion_on ? (magnetometer_enable_bit_in ? FMT_INCR_MAG : FMT_INCR) : FMT_RAW;
      device_state_out  <= st_r;
    end
  end

  // Sample capture; held untouched outside active so power-down keeps it
  assign sample_evt = active & ~cfg_r[3] & ~cfg_r[4] &
                      ((polled_sample_select_in & fusion_on) ? poll_request_in : odr_tick);
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sample_out     <= '0;
      data_ready_out <= 1'b0;
    end else begin
      data_ready_out <= sample_evt | stab_fire;
      if (sample_evt | stab_fire) sample_out <= gyro_sample_in;
    end
  end

  // Interrupt pins: wake window on the second pin, sample strobes per mode
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pulse_cnt_r              <= '0;
      first_interrupt_pin_out  <= 1'b1;
      second_interrupt_pin_out <= 1'b0;
    end else begin
      if (stab_fire) pulse_cnt_r <= PULSE_W'(PIN_PULSE_CYC);
      else if (pulse_cnt_r != '0) pulse_cnt_r <= pulse_cnt_r - 1'b1;
      first_interrupt_pin_out  <= ~((stab_fire | (pulse_cnt_r > 1)) & cfg_r[3]);
      second_interrupt_pin_out <= (st_r == ST_WAKE) || (st_r == ST_SETTLE) ||
                                  ((stab_fire | (pulse_cnt_r > 1)) & cfg_r[4]);
    end
  end

  // Host SPI clock and select pass two flops before any edge logic
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sclk_sync_r <= '0;
      csn_sync_r  <= 2'h3;
      sclk_d_r    <= 1'b0;
      csn_d_r     <= 1'b1;
    end else begin
      sclk_sync_r <= {sclk_sync_r[0], spi_sclk_in};
      csn_sync_r  <= {csn_sync_r[0], spi_cs_n_in};
      sclk_d_r    <= sclk_sync_r[1];
      csn_d_r     <= csn_sync_r[1];
    end
  end
  assign sclk_fall = sclk_d_r & ~sclk_sync_r[1];
  assign cs_start  = csn_d_r & ~csn_sync_r[1];

  // Stream shifter, MSB first, advanced on host clock falls
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      shift_r <= '0;
      drive_r <= 1'b0;
    end else begin
      if (cs_start) shift_r <= sample_out;
      else if (!csn_sync_r[1] && sclk_fall) shift_r <= {shift_r[DATA_W-2:0], 1'b0};
      drive_r <= ~csn_sync_r[1] & active & (cfg_r[3] | cfg_r[4]);
    end
  end

  // One pin per wire mode; both share the shifter output
  assign spi_sdo_out     = shift_r[DATA_W-1];
  assign spi_sdio_out    = shift_r[DATA_W-1];
  assign spi_sdo_oe_out  = drive_r & ~serial_wire_count_select_in;
  assign spi_sdio_oe_out = drive_r & serial_wire_count_select_in;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  sequence s_wake_enter;
    (st_r == ST_DEFAULT) ##1 (st_r == ST_WAKE);
  endsequence
  sequence s_off_done;
    (st_r == ST_OFF) && off_armed_r && (cnt_r == '0);
  endsequence
  property p_plain_no_accel;
    (active && cfg_r[3]) |=> !accel_power_out;
  endproperty
  a_plain_no_accel: assert property (p_plain_no_accel) else $error("accel on in plain mode");
  property p_plain_first_interrupt_pin;
    (stab_fire && cfg_r[3]) |=> (!first_interrupt_pin_out)[*4] ##1 first_interrupt_pin_out;
  endproperty
  a_plain_first_interrupt_pin: assert property (p_plain_first_interrupt_pin) else $error("first pin strobe wrong");
  property p_ll_second_interrupt_pin;
    (stab_fire && cfg_r[4]) |=> $rose(second_interrupt_pin_out);
  endproperty
  a_ll_second_interrupt_pin: assert property (p_ll_second_interrupt_pin) else $error("second pin did not rise");
  property p_ll_accel;
    (active && cfg_r[4] && cfg_r[1]) |=> accel_power_out && first_interrupt_pin_out;
  endproperty
  a_ll_accel: assert property (p_ll_accel) else $error("accel off in low latency");
  property p_wire_sel;
    spi_sdo_oe_out |-> !spi_sdio_oe_out && $past(active);
  endproperty
  a_wire_sel: assert property (p_wire_sel) else $error("both data pins driven");
  property p_format;
    (fusion_on && $stable(magnetometer_enable_bit_in)) |=>
      output_format_out == ($past(magnetometer_enable_bit_in) ? FMT_INCR_MAG : FMT_INCR);
  endproperty
  a_format: assert property (p_format) else $error("fusion format wrong");
  property p_poll;
    (active && !cfg_r[3] && !cfg_r[4] && polled_sample_select_in && fusion_on)
      |=> data_ready_out == $past(poll_request_in);
  endproperty
  a_poll: assert property (p_poll) else $error("polled sample mismatch");
  property p_boot;
    ((st_r == ST_BOOT) && (cnt_r == '0)) |=> (st_r == ST_DEFAULT) ##1 clock_run_out;
  endproperty
  a_boot: assert property (p_boot) else $error("boot did not end in default");
  property p_wake;
    s_wake_enter |=> second_interrupt_pin_out && !data_valid_out;
  endproperty
  a_wake: assert property (p_wake) else $error("wake window not marked");
  property p_valid;
    $rose(data_valid_out) |-> $past(st_r, 2) == ST_SETTLE;
  endproperty
  a_valid: assert property (p_valid) else $error("valid before settling");
  property p_off;
    s_off_done |=> (st_r == ST_DEFAULT) ##1 (!gyro_power_out && !accel_power_out);
  endproperty
  a_off: assert property (p_off) else $error("power-off sequence wrong");
  property p_switch;
    ((st_r == ST_SWITCH) && (cnt_r == '0)) |=> (st_r == ST_DOWN) ##1 !clock_run_out;
  endproperty
  a_switch: assert property (p_switch) else $error("switch to power-down wrong");
  property p_default;
    (st_r == ST_DEFAULT) |=> !gyro_power_out && !accel_power_out && !mag_power_out && clock_run_out;
  endproperty
  a_default: assert property (p_default) else $error("default state not idle");
  property p_down;
    ((st_r == ST_DOWN) && $past(st_r == ST_DOWN)) |-> $stable(sample_out) && !fusion_power_out;
  endproperty
  a_down: assert property (p_down) else $error("power-down lost data");

endmodule

// ### imtc_host_model.sv
`timescale 1ns/1ps
module imtc_host_model (
  input  wire logic ref_clk_in,
  input  wire logic three_wire_in,
  input  wire logic spi_sdo_in,
  input  wire logic spi_sdo_oe_in,
  input  wire logic spi_sdio_in,
  input  wire logic spi_sdio_oe_in,
  output logic      spi_sclk_out,
  output logic      spi_cs_n_out
);
  logic line_sdo;
  logic line_sdio;

  // Released lines show the inverse, so a stale bit never reads as good
  assign line_sdo  = spi_sdo_oe_in ? spi_sdo_in : ~spi_sdo_in;
  assign line_sdio = spi_sdio_oe_in ? spi_sdio_in : ~spi_sdio_in;

  // Clock stands high outside frames
  initial begin
    spi_sclk_out = 1'b1;
    spi_cs_n_out = 1'b1;
  end

  // One 48-bit frame, MSB first, 800 ns clock
  task automatic read_frame(output logic [47:0] data);
    @(posedge ref_clk_in);
    #10 spi_cs_n_out = 1'b0;
    repeat (8) @(posedge ref_clk_in);
    #10;
    for (int i = 47; i >= 0; i--) begin
      data[i] = three_wire_in ? line_sdio : line_sdo;
      spi_sclk_out = 1'b0;
      repeat (4) @(posedge ref_clk_in);
      #10 spi_sclk_out = 1'b1;
      repeat (4) @(posedge ref_clk_in);
      #10;
    end
    spi_cs_n_out = 1'b1;
  endtask
endmodule

// ### tb.sv
`timescale 1ns/1ps
module tb;
  import imtc_pkg::*;
  localparam logic [47:0] SMP         = 48'ha5c3_0f1e_9b27;
  localparam int unsigned ODR_TAB [8] = '{16, 16, 16, 16, 16, 16, 16, 16};
  logic ref_clk_in, rst_in, a_en, g_en, m_en, f_en, polled, three_w, shut, spi_host, poll;
  logic sclk, cs_n, sdo, sdo_oe, sdio, sdio_oe, first_interrupt_pin, second_interrupt_pin, gp, ap, mp, fp, crun, dval, drdy;
  logic [2:0]  g_rate, dstate, a_rate;
  logic [1:0]  fmt;
  logic [47:0] smp_out, frame, smp_in;
  int          n_mismatch = 0;
  int          num_checks = 0;
  int          n;

  imtc_mode_ctrl #(.TURN_ON_CYCLES(50), .GYRO_WAKE_CYCLES(20), .ACCEL_WAKE_CYCLES(5), .MAG_WAKE_CYCLES(10),
    .WARM_WAKE_CYCLES(8), .ODR_PERIOD_CYC(ODR_TAB)) dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .gyro_rate_select_in(g_rate), .accel_rate_select_in(a_rate), .accel_enable_bit_in(a_en),
    .gyro_enable_bit_in(g_en), .magnetometer_enable_bit_in(m_en), .fusion_engine_enable_bit_in(f_en),
    .polled_sample_select_in(polled), .serial_wire_count_select_in(three_w), .sensor_shutdown_bit_in(shut),
    .host_iface_spi_in(spi_host), .poll_request_in(poll), .gyro_sample_in(smp_in), .spi_sclk_in(sclk),
    .spi_cs_n_in(cs_n), .spi_sdo_out(sdo), .spi_sdo_oe_out(sdo_oe), .spi_sdio_out(sdio),
    .spi_sdio_oe_out(sdio_oe), .first_interrupt_pin_out(first_interrupt_pin), .second_interrupt_pin_out(second_interrupt_pin),
    .gyro_power_out(gp), .accel_power_out(ap), .mag_power_out(mp), .fusion_power_out(fp),
    .clock_run_out(crun), .data_valid_out(dval), .data_ready_out(drdy), .output_format_out(fmt),
    .sample_out(smp_out), .device_state_out(dstate));

  imtc_host_model host (.ref_clk_in(ref_clk_in), .three_wire_in(three_w), .spi_sdo_in(sdo),
    .spi_sdo_oe_in(sdo_oe), .spi_sdio_in(sdio), .spi_sdio_oe_in(sdio_oe), .spi_sclk_out(sclk),
    .spi_cs_n_out(cs_n));

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic [47:0] got, input logic [47:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  task automatic rng(input int v, input int lo, input int hi, input string what);
    check(48'(v >= lo && v <= hi), 48'h1, what);
  endtask

  // Inputs move 10 ns after the edge
  task automatic tick(input int c);
    repeat (c) @(posedge ref_clk_in);
    #10;
  endtask

  // Bounded wait, so a stuck sequencer shows up as a mismatch
  task automatic wait_st(input logic [2:0] s, input int lim);
    n = 0;
    while (dstate !== s && n < lim) begin
      tick(1);
      n++;
    end
    check(48'(dstate), 48'(s), "state reached");
  endtask

  task automatic mode_up(input logic [3:0] agmf, input int wake);
    {a_en, g_en, m_en, f_en} = agmf;
    polled = agmf[0];
    wait_st(ST_WAKE, 5);
    tick(1);
    check(48'({second_interrupt_pin, dval}), 48'h2, "wake marker, valid withheld");
    wait_st(ST_SETTLE, wake + 5);
    rng(n + 1, wake - 1, wake + 1, "wake time");
    wait_st(ST_ACTIVE, 60);
    rng(n, 47, 49, "settle time");
    tick(1);
    check(48'(dval), 48'h1, "valid after settle");
    check(48'(fmt), (agmf[3] & agmf[2] & agmf[0]) ? 48'(1 + agmf[1]) : 48'h0, "format");
    check(48'({gp, mp, fp}), 48'({agmf[2], agmf[1], agmf[3] & agmf[2] & agmf[0]}), "sensor power");
  endtask

  task automatic mode_down();
    {a_en, g_en, m_en, f_en, polled} = 5'h0;
    // A stabilization rate alone keeps the gyro wanted, and a stale warm rate would shorten the next wake
    g_rate = 3'h0;
    wait_st(ST_OFF, 5);
    wait_st(ST_DEFAULT, 40);
    rng(n, 15, 33, "power-off time");
    tick(1);
    check(48'({gp, ap, mp, fp, crun}), 48'h1, "sensors off, clock on");
  endtask

  task automatic t_boot();
    tick(2);
    check(48'({first_interrupt_pin, second_interrupt_pin, dstate, crun, dval}), 48'h40, "reset levels");
    rst_in = 1'b0;
    wait_st(ST_DEFAULT, 80);
    rng(n, 49, 52, "turn-on time");
    $display("test boot done");
  endtask

  // Gyro, accel, mag and accel plus mag alone, the fusion formats with a poll, then warm start
  task automatic t_modes();
    mode_up(4'b0100, 20);
    mode_down();
    mode_up(4'b1000, 5);
    mode_down();
    mode_up(4'b0010, 10);
    mode_down();
    mode_up(4'b1010, 10);
    mode_down();
    mode_up(4'b1101, 20);
    poll = 1'b1;
    tick(1);
    poll = 1'b0;
    check(48'(drdy), 48'h1, "poll answered");
    mode_down();
    mode_up(4'b1111, 20);
    mode_down();
    g_rate = GYRO_RATE_WARM;
    tick(3);
    mode_up(4'b0100, 8);
    mode_down();
    $display("test modes done");
  endtask

  task automatic t_stab(input logic [2:0] rate, input logic three, input logic [2:0] arate);
    g_rate = rate;
    three_w = three;
    a_rate = arate;
    // Fresh sample each run, so a stale capture cannot pass
    smp_in = ~smp_in;
    mode_up(4'b1100, 20);
    tick(2);
    n = 0;
    while ((rate[0] ? second_interrupt_pin !== 1'b1 : first_interrupt_pin !== 1'b0) && n < 1300) begin
      tick(1);
      n++;
    end
    check(48'({rate[0] ? second_interrupt_pin : ~first_interrupt_pin, ap}), 48'({1'b1, rate[0] & ~|arate}), "marker, accel");
    check(smp_out, smp_in, "captured sample");
    host.read_frame(frame);
    check(frame, smp_in, "streamed frame");
    mode_down();
    $display("test stabilization done");
  endtask

  task automatic t_down(input logic spi, input int exp);
    spi_host = spi;
    shut = 1'b1;
    wait_st(ST_SWITCH, 5);
    wait_st(ST_DOWN, 1100);
    rng(n, exp - 2, exp + 1, "off-to-off time");
    tick(1);
    check({smp_out[46:0], crun}, {smp_in[46:0], 1'b0}, "down keeps data");
    shut = 1'b0;
    wait_st(ST_BOOT, 5);
    wait_st(ST_DEFAULT, 80);
    $display("test power-down done");
  endtask

  initial begin
    ref_clk_in = 1'b0;
    forever #50 ref_clk_in = ~ref_clk_in;
  end

  // Reset once at start only, since it forces a full reboot
  initial begin
    {a_en, g_en, m_en, f_en, polled, three_w, shut, poll} = 8'h0;
    a_rate = 3'h0;
    smp_in = SMP;
    rst_in = 1'b1;
    g_rate = 3'h0;
    spi_host = 1'b1;
    t_boot();
    t_modes();
    t_stab(GYRO_RATE_STAB, 1'b0, 3'h0);
    t_stab(GYRO_RATE_STAB_LL, 1'b1, 3'h0);
    t_stab(GYRO_RATE_STAB_LL, 1'b0, 3'h1);
    t_down(1'b1, 400);
    t_down(1'b0, 999);
    close_out();
  end

  initial begin
    repeat (20000) @(posedge ref_clk_in);
    n_mismatch++;
    $display("mismatch at %0t: watchdog expired", $time);
    close_out();
  end
endmodule
